// ==== logic/slip_ctrl_pkg.sv ====
package slip_ctrl_pkg;

  // Register byte offsets on the Wishbone bus
  localparam logic [7:0] SLIP_CTRL_OFFS = 8'h00;
  localparam logic [7:0] FIFO_LAT_OFFS = 8'h04;
  localparam logic [7:0] STATUS_OFFS = 8'h08;
  localparam logic [7:0] SIG_ARRAY_BASE = 8'h80;

  // Control field positions
  localparam int TX_FIFO_BIT = 7;
  localparam int FORCE_HOLD_BIT = 4;
  localparam int SLIP_HOLD_BIT = 3;
  localparam int SYNC_DIR_BIT = 2;
  localparam int MODE_LSB = 0;

  // Status field positions
  localparam int ST_SLIP_HOLD_BIT = 0;
  localparam int ST_FROZEN_BIT = 1;
  localparam int ST_LEVEL_LSB = 8;

  // Reset values
  localparam logic [7:0] SLIP_CTRL_RESET = 8'h05;
  localparam logic [4:0] FIFO_LAT_RESET = 5'h00;
  localparam logic [3:0] SIG_RESET = 4'h0;

  // Sizes
  localparam int LAT_W = 5;
  localparam int SIG_W = 4;
  localparam int TS_W = 5;
  localparam int RX_FIFO_DEPTH = 32;

  // Receive buffer modes
  typedef enum logic [1:0] {
    RX_BYPASS0 = 2'b00,
    RX_SLIP = 2'b01,
    RX_FIFO = 2'b10,
    RX_BYPASS3 = 2'b11
  } rx_mode_e;

  // Slip-triggered hold sequence
  typedef enum logic [1:0] {
    HOLD_IDLE = 2'b00,
    HOLD_WAIT_MF = 2'b01,
    HOLD_FULL_MF = 2'b10
  } hold_state_e;

  // Layout of the control register
  typedef struct packed {
    logic tx_buffer_fifo_select;
    logic [1:0] reserved;
    logic force_signaling_hold;
    logic slip_triggered_hold_enable;
    logic rx_frame_sync_direction;
    rx_mode_e rx_buffer_mode_select;
  } slip_ctrl_s;

  // One new signaling value for one timeslot
  typedef struct packed {
    logic valid;
    logic [TS_W-1:0] timeslot;
    logic [SIG_W-1:0] value;
  } sig_upd_s;

endpackage

// ==== logic/stream_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH):0] level_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic push, pop;

  // Extra pointer bit tells full from empty
  always_comb begin
    in_ready_o = (wr_r - rd_r) != (AW+1)'(DEPTH);
    out_valid_o = wr_r != rd_r;
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    wr_nxt = push ? wr_r + 1'b1 : wr_r;
    rd_nxt = pop ? rd_r + 1'b1 : rd_r;
    out_data_o = mem[rd_r[AW-1:0]];
    level_o = wr_r - rd_r;
  end

  // Pointers and storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
    end
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

// ==== logic/slip_buffer_signaling_freeze_ctrl.sv ====
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Tx buffer: 0 slip buffer, 1 FIFO
// - Tx buffer only in high-speed, clock input
// - Tx FIFO delay from latency register
// - Forced hold blocks signaling pin and array
// - No forced hold and no slip hold: signaling passes immediately
// - Slip with enable holds signaling until the second multiframe boundary
// - Buffer enabled: direction bit sets frame pin
// - Buffer bypassed: frame pin always output
// - Mode field: bypass, slip or FIFO
// - Rx FIFO delays data by latency periods
module slip_buffer_signaling_freeze_ctrl (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Framer side, same clock
  input wire slip_ctrl_pkg::sig_upd_s sig_upd_i,
  input wire logic mf_boundary_i,
  input wire logic rx_slip_i,
  input wire logic frame_sync_i,
  input wire logic recovered_clk_i,
  input wire logic backplane_hs_i,
  // Receive pins
  input wire logic rx_serial_clock_i,
  output logic rx_serial_clock_o,
  output logic rx_serial_clock_oe_o,
  input wire logic rx_data_i,
  output logic rx_data_o,
  input wire logic rx_frame_boundary_i,
  output logic rx_frame_boundary_o,
  output logic rx_frame_boundary_oe_o,
  output logic rx_frame_sync_o,
  output logic [slip_ctrl_pkg::SIG_W-1:0] rx_signaling_output_pin_o,
  // Transmit buffer control
  output logic tx_serial_clock_oe_o,
  output logic tx_buffer_enable_o,
  output logic tx_buffer_fifo_select_o,
  output logic [slip_ctrl_pkg::LAT_W-1:0] tx_fifo_latency_o
);
  import slip_ctrl_pkg::*;

  localparam int LVL_W = $clog2(RX_FIFO_DEPTH) + 1;

  // Register state
  slip_ctrl_s ctrl_r, ctrl_nxt;
  logic [LAT_W-1:0] lat_r, lat_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic [SIG_W-1:0] sig_array_r [32];

  // Pin synchronisers: stage one feeds stage two only
  logic [2:0] sync1_r, sync2_r, sync1_nxt, sync2_nxt;
  logic clk_prev_r, clk_prev_nxt;
  logic rx_edge;

  // Hold sequence and signaling
  hold_state_e hold_r, hold_nxt;
  logic frozen;
  logic [SIG_W-1:0] sig_pin_r, sig_pin_nxt;
  logic array_we;

  // Receive datapath and pins
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready, fifo_out_data;
  logic [LVL_W-1:0] fifo_level;
  logic rx_data_r, rx_data_nxt;
  logic bypass;
  logic rclk_r, rclk_oe_r, fb_r, fb_oe_r, fs_r;
  logic rclk_nxt, rclk_oe_nxt, fb_nxt, fb_oe_nxt, fs_nxt;
  logic txc_oe_r, txe_r, txf_r, txc_oe_nxt, txe_nxt, txf_nxt;
  logic [LAT_W-1:0] txl_r, txl_nxt;

  // Both bypass codes decode the same way
  function automatic logic is_bypass(input rx_mode_e m);
    return (m == RX_BYPASS0) || (m == RX_BYPASS3);
  endfunction

  // Single-beat bus access: byte address, answer one cycle later
  logic bus_req, bus_wr;
  logic [4:0] arr_idx;
  always_comb begin
    bus_req = wb_cyc_i && wb_stb_i && !ack_r;
    bus_wr = bus_req && wb_we_i && wb_sel_i[0];
    arr_idx = wb_adr_i[6:2];
    ack_nxt = bus_req;
    ctrl_nxt = ctrl_r;
    lat_nxt = lat_r;
    rdat_nxt = 32'h0000_0000;
    if (bus_wr && wb_adr_i == SLIP_CTRL_OFFS) begin
      ctrl_nxt = slip_ctrl_s'(wb_dat_i[7:0]);
      ctrl_nxt.reserved = 2'b00; // Reserved bits stay zero
    end
    if (bus_wr && wb_adr_i == FIFO_LAT_OFFS) begin
      lat_nxt = wb_dat_i[LAT_W-1:0];
    end
    if (bus_req && !wb_we_i) begin
      if (wb_adr_i == SLIP_CTRL_OFFS) begin
        rdat_nxt[7:0] = ctrl_r;
      end else if (wb_adr_i == FIFO_LAT_OFFS) begin
        rdat_nxt[LAT_W-1:0] = lat_r;
      end else if (wb_adr_i == STATUS_OFFS) begin
        rdat_nxt[ST_SLIP_HOLD_BIT] = hold_r != HOLD_IDLE;
        rdat_nxt[ST_FROZEN_BIT] = frozen;
        rdat_nxt[ST_LEVEL_LSB +: LVL_W] = fifo_level;
      end else if (wb_adr_i[7] && wb_adr_i[1:0] == 2'b00) begin
        rdat_nxt[SIG_W-1:0] = sig_array_r[arr_idx];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= slip_ctrl_s'(SLIP_CTRL_RESET);
      lat_r <= FIFO_LAT_RESET;
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      lat_r <= lat_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // Order: clock, data, frame boundary
  always_comb begin
    sync1_nxt = {rx_frame_boundary_i, rx_data_i, rx_serial_clock_i};
    sync2_nxt = sync1_r;
    clk_prev_nxt = sync2_r[0];
    rx_edge = sync2_r[0] && !clk_prev_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= 3'b000;
      sync2_r <= 3'b000;
      clk_prev_r <= 1'b0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      clk_prev_r <= clk_prev_nxt;
    end
  end

  // A slip restarts the wait, so overlapping slips extend the hold
  always_comb begin
    hold_nxt = hold_r;
    unique case (hold_r)
      HOLD_IDLE: begin
        if (rx_slip_i && ctrl_r.slip_triggered_hold_enable) begin
          hold_nxt = HOLD_WAIT_MF;
        end
      end
      HOLD_WAIT_MF: begin
        if (mf_boundary_i) begin
          hold_nxt = HOLD_FULL_MF;
        end
      end
      HOLD_FULL_MF: begin
        if (mf_boundary_i) begin
          hold_nxt = HOLD_IDLE;
        end
      end
      default: hold_nxt = HOLD_IDLE;
    endcase
    if (hold_r != HOLD_IDLE && rx_slip_i && ctrl_r.slip_triggered_hold_enable) begin
      hold_nxt = HOLD_WAIT_MF;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_r <= HOLD_IDLE;
    end else begin
      hold_r <= hold_nxt;
    end
  end

  // Updates that arrive while frozen are dropped, not queued
  always_comb begin
    frozen = ctrl_r.force_signaling_hold || hold_r != HOLD_IDLE;
    array_we = sig_upd_i.valid && !frozen;
    sig_pin_nxt = array_we ? sig_upd_i.value : sig_pin_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sig_pin_r <= SIG_RESET;
      for (int i = 0; i < 32; i++) begin
        sig_array_r[i] <= SIG_RESET;
      end
    end else begin
      sig_pin_r <= sig_pin_nxt;
      if (array_we) begin
        sig_array_r[sig_upd_i.timeslot] <= sig_upd_i.value;
      end
    end
  end

  assign rx_signaling_output_pin_o = sig_pin_r;

  // One bit enters per rising rx clock edge; a full FIFO drops the incoming bit
  stream_fifo #(
    .WIDTH(1),
    .DEPTH(RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(rx_edge),
    .in_ready_o(fifo_in_ready),
    .in_data_i(sync2_r[1]),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data),
    .level_o(fifo_level)
  );

  // Outside FIFO mode the buffer drains freely so it never stays full
  always_comb begin
    bypass = is_bypass(ctrl_r.rx_buffer_mode_select);
    fifo_out_ready = ctrl_r.rx_buffer_mode_select != RX_FIFO ||
                     (rx_edge && fifo_level > LVL_W'(lat_r));
    rx_data_nxt = rx_data_r;
    if (ctrl_r.rx_buffer_mode_select == RX_FIFO) begin
      if (fifo_out_valid && fifo_out_ready) begin
        rx_data_nxt = fifo_out_data;
      end
    end else if (rx_edge) begin
      rx_data_nxt = sync2_r[1];
    end
  end

  // Pin directions and transmit buffer settings
  always_comb begin
    rclk_oe_nxt = bypass;
    rclk_nxt = recovered_clk_i;
    fb_oe_nxt = bypass || !ctrl_r.rx_frame_sync_direction;
    fb_nxt = frame_sync_i;
    fs_nxt = fb_oe_r ? frame_sync_i : sync2_r[2];
    txe_nxt = backplane_hs_i;
    txc_oe_nxt = 1'b0;
    txf_nxt = ctrl_r.tx_buffer_fifo_select;
    txl_nxt = ctrl_r.tx_buffer_fifo_select ? lat_r : FIFO_LAT_RESET;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_data_r <= 1'b0;
      rclk_r <= 1'b0;
      rclk_oe_r <= 1'b0;
      fb_r <= 1'b0;
      fb_oe_r <= 1'b0;
      fs_r <= 1'b0;
      txc_oe_r <= 1'b0;
      txe_r <= 1'b0;
      txf_r <= 1'b0;
      txl_r <= FIFO_LAT_RESET;
    end else begin
      rx_data_r <= rx_data_nxt;
      rclk_r <= rclk_nxt;
      rclk_oe_r <= rclk_oe_nxt;
      fb_r <= fb_nxt;
      fb_oe_r <= fb_oe_nxt;
      fs_r <= fs_nxt;
      txc_oe_r <= txc_oe_nxt;
      txe_r <= txe_nxt;
      txf_r <= txf_nxt;
      txl_r <= txl_nxt;
    end
  end

  assign rx_data_o = rx_data_r;
  assign rx_serial_clock_o = rclk_r;
  assign rx_serial_clock_oe_o = rclk_oe_r;
  assign rx_frame_boundary_o = fb_r;
  assign rx_frame_boundary_oe_o = fb_oe_r;
  assign rx_frame_sync_o = fs_r;
  assign tx_serial_clock_oe_o = txc_oe_r;
  assign tx_buffer_enable_o = txe_r;
  assign tx_buffer_fifo_select_o = txf_r;
  assign tx_fifo_latency_o = txl_r;

  // Checks on the block's own outputs, hold state and FIFO level
  tx_mode_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 tx_buffer_fifo_select_o == $past(ctrl_r.tx_buffer_fifo_select))
    else $error("tx buffer mode does not follow control");
  tx_clk_input_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_buffer_enable_o |-> !tx_serial_clock_oe_o)
    else $error("tx clock driven while tx buffer in use");
  tx_latency_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 $past(ctrl_r.tx_buffer_fifo_select) |-> tx_fifo_latency_o == $past(lat_r))
    else $error("tx FIFO latency not taken from register");
  force_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_r.force_signaling_hold |=> $stable(rx_signaling_output_pin_o))
    else $error("signaling pin changed while forced hold");
  sig_pass_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sig_upd_i.valid && !ctrl_r.force_signaling_hold && hold_r == HOLD_IDLE
    |=> rx_signaling_output_pin_o == $past(sig_upd_i.value))
    else $error("signaling update not passed through");
  slip_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_slip_i && ctrl_r.slip_triggered_hold_enable |=> hold_r == HOLD_WAIT_MF)
    else $error("slip did not start signaling hold");
  no_slip_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hold_r == HOLD_IDLE && !ctrl_r.slip_triggered_hold_enable |=> hold_r == HOLD_IDLE)
    else $error("hold started while disabled");
  sync_dir_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !bypass ##1 $stable(ctrl_r) |-> rx_frame_boundary_oe_o == !ctrl_r.rx_frame_sync_direction)
    else $error("frame boundary direction wrong");
  bypass_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bypass |=> rx_frame_boundary_oe_o && rx_serial_clock_oe_o)
    else $error("frame boundary not output in bypass");
  fifo_latency_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_r.rx_buffer_mode_select == RX_FIFO && rx_edge && fifo_level > LVL_W'(lat_r)
    |=> fifo_level <= $past(fifo_level))
    else $error("rx FIFO grew past its latency");
  hold_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hold_r == HOLD_FULL_MF && mf_boundary_i && !rx_slip_i |=> hold_r == HOLD_IDLE)
    else $error("hold not released at multiframe boundary");
endmodule
`default_nettype wire

// ==== verification/backplane_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module backplane_model (
  // Control from the bench
  input wire logic run_i,
  // Lines toward the framer
  output logic ser_clk_o,
  output logic ser_data_o = 1'b0,
  output logic fsync_o = 1'b0
);
  logic [2:0] bit_cnt = 3'h0;

  // Rx clock of 400 ns runs only while run_i is high and rests low otherwise
  // The odd start offset keeps its edges off the system clock edges
  initial begin
    ser_clk_o = 1'b0;
    #37;
    forever begin
      #200;
      ser_clk_o = run_i ? ~ser_clk_o : 1'b0;
    end
  end

  // Data and frame sync leave on the falling edge, timed from that same clock
  always @(negedge ser_clk_o) begin
    bit_cnt <= bit_cnt + 3'h1;
    ser_data_o <= bit_cnt[0] ^ bit_cnt[2];
    fsync_o <= (bit_cnt == 3'h7);
  end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import slip_ctrl_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, hs = 1'b0, mf = 1'b0, slip = 1'b0, run = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic [1:0] intl = 2'h0;
  sig_upd_s upd = '0;
  int errors = 0, checks = 0;
  wire logic ack, rclk_o, rclk_oe, fb_o, fb_oe, p_clk, p_dat, p_fs, txoe, txen, txsel, fs_o, rdo;
  wire logic [31:0] dat_o;
  wire logic [3:0] sig_pin;
  wire logic [4:0] txlat;
  // Two-way pins: whoever has its enable up sets the wire
  wire logic rclk_w = rclk_oe ? rclk_o : p_clk;
  wire logic fb_w = fb_oe ? fb_o : p_fs;

  // Clock, plus slow internal clock and frame levels from a counter
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) intl <= intl + 2'h1;

  slip_buffer_signaling_freeze_ctrl i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(dat_o), .wb_ack_o(ack), .sig_upd_i(upd),
    .mf_boundary_i(mf), .rx_slip_i(slip), .frame_sync_i(intl[1]), .recovered_clk_i(intl[0]),
    .backplane_hs_i(hs), .rx_serial_clock_i(rclk_w), .rx_serial_clock_o(rclk_o),
    .rx_serial_clock_oe_o(rclk_oe), .rx_data_i(p_dat), .rx_data_o(rdo), .rx_frame_boundary_i(fb_w),
    .rx_frame_boundary_o(fb_o), .rx_frame_boundary_oe_o(fb_oe), .rx_frame_sync_o(fs_o),
    .rx_signaling_output_pin_o(sig_pin), .tx_serial_clock_oe_o(txoe), .tx_buffer_enable_o(txen),
    .tx_buffer_fifo_select_o(txsel), .tx_fifo_latency_o(txlat));

  backplane_model i_bp (.run_i(run), .ser_clk_o(p_clk), .ser_data_o(p_dat), .fsync_o(p_fs));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask

  // One classic cycle; the slave's answer time is never assumed
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n == 20) errors++;
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    check(rdat, e);
  endtask

  // Let registered outputs land before looking
  task tick;
    @(posedge clk_i);
    #1;
  endtask

  task sig(input logic [4:0] ts, input logic [3:0] v);
    @(posedge clk_i);
    upd <= '{valid: 1'b1, timeslot: ts, value: v};
    @(posedge clk_i);
    upd <= '0;
    tick;
  endtask

  task pulse(input logic is_slip);
    @(posedge clk_i);
    if (is_slip) slip <= 1'b1;
    else mf <= 1'b1;
    @(posedge clk_i);
    slip <= 1'b0;
    mf <= 1'b0;
  endtask

  task t_reset;
    rdc(SLIP_CTRL_OFFS, 32'h05);
    rdc(FIFO_LAT_OFFS, 32'h00);
    rdc(STATUS_OFFS, 32'h00);
    bus(8'h40, 1'b1, 32'hFF);
    rdc(8'h40, 32'h00);
    bus(SLIP_CTRL_OFFS, 1'b1, 32'hFF);
    rdc(SLIP_CTRL_OFFS, 32'h9F);
    check(32'(txoe), 32'h0);
    $display("t_reset done");
  endtask

  // Every mode code against both direction settings
  // Third tick lets the old pin level leave the synchroniser before frame sync is judged
  task t_modes;
    logic [1:0] prv;
    logic e_oe;
    for (int m = 0; m < 8; m++) begin
      bus(SLIP_CTRL_OFFS, 1'b1, 32'(m));
      tick;
      tick;
      tick;
      prv = intl - 2'h1;
      e_oe = m[1:0] == 2'h0 || m[1:0] == 2'h3 || !m[2];
      check(32'(rclk_oe), 32'(m[1:0] == 2'h0 || m[1:0] == 2'h3));
      check(32'(fb_oe), 32'(m[1:0] == 2'h0 || m[1:0] == 2'h3 || !m[2]));
      check(32'(rclk_o), 32'(prv[0]));
      check(32'(fb_o), 32'(prv[1]));
      check(32'(fs_o), 32'(e_oe ? prv[1] : 1'b0));
    end
    $display("t_modes done");
  endtask

  task t_tx;
    @(posedge clk_i);
    hs <= 1'b1;
    bus(FIFO_LAT_OFFS, 1'b1, 32'h1F);
    bus(SLIP_CTRL_OFFS, 1'b1, 32'h85);
    tick;
    tick;
    check(32'(txsel), 32'h1);
    check(32'(txlat), 32'h1F);
    check(32'(txen), 32'h1);
    check(32'(txoe), 32'h0);
    bus(SLIP_CTRL_OFFS, 1'b1, 32'h05);
    hs <= 1'b0;
    tick;
    tick;
    check(32'(txsel), 32'h0);
    check(32'(txlat), 32'h00);
    check(32'(txen), 32'h0);
    $display("t_tx done");
  endtask

  task t_force;
    sig(5'd3, 4'hA);
    check(32'(sig_pin), 32'hA);
    rdc(SIG_ARRAY_BASE + 8'h0C, 32'hA);
    bus(SLIP_CTRL_OFFS, 1'b1, 32'h15);
    sig(5'd3, 4'h5);
    check(32'(sig_pin), 32'hA);
    rdc(SIG_ARRAY_BASE + 8'h0C, 32'hA);
    rdc(STATUS_OFFS, 32'h2);
    bus(SLIP_CTRL_OFFS, 1'b1, 32'h05);
    sig(5'd31, 4'hF);
    check(32'(sig_pin), 32'hF);
    rdc(SIG_ARRAY_BASE + 8'h7C, 32'hF);
    $display("t_force done");
  endtask

  // Hold must span the first boundary and end at the second
  task t_slip;
    pulse(1'b1);
    sig(5'd1, 4'h3);
    check(32'(sig_pin), 32'h3);
    bus(SLIP_CTRL_OFFS, 1'b1, 32'h0D);
    pulse(1'b1);
    sig(5'd1, 4'h7);
    check(32'(sig_pin), 32'h3);
    rdc(STATUS_OFFS, 32'h3);
    pulse(1'b0);
    sig(5'd1, 4'h8);
    check(32'(sig_pin), 32'h3);
    pulse(1'b0);
    tick;
    sig(5'd1, 4'h9);
    check(32'(sig_pin), 32'h9);
    rdc(SIG_ARRAY_BASE + 8'h04, 32'h9);
    $display("t_slip done");
  endtask

  // Rx FIFO settles at its latency, fills to the brim, then drains in slip mode
  // One period of the data pattern spans 64 cycles and holds four ones of eight bits
  task t_fifo;
    int ones;
    bus(FIFO_LAT_OFFS, 1'b1, 32'h04);
    bus(SLIP_CTRL_OFFS, 1'b1, 32'h06);
    run <= 1'b1;
    repeat (400) @(posedge clk_i);
    bus(STATUS_OFFS, 1'b0, 32'h0);
    check(32'(rdat[13:8] inside {6'd4, 6'd5}), 32'h1);
    ones = 0;
    repeat (64) begin
      @(posedge clk_i);
      ones += int'(rdo);
    end
    check(32'(ones), 32'h20);
    bus(FIFO_LAT_OFFS, 1'b1, 32'h1F);
    repeat (400) @(posedge clk_i);
    bus(STATUS_OFFS, 1'b0, 32'h0);
    check(32'(rdat[13:8] inside {6'd31, 6'd32}), 32'h1);
    bus(SLIP_CTRL_OFFS, 1'b1, 32'h05);
    run <= 1'b0;
    repeat (64) @(posedge clk_i);
    rdc(STATUS_OFFS, 32'h0);
    $display("t_fifo done");
  endtask

  task results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence after ten cycles of reset
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_modes;
    t_tx;
    t_force;
    t_slip;
    t_fifo;
    results;
  end

  // Watchdog: the tests need well under a tenth of this
  initial begin
    #1000000;
    errors++;
    results;
  end
endmodule
`default_nettype wire
